/* core/bt_wdt_ctrl.sv */
// Basic timer, watchdog and system clock divider control with an Avalon-MM slave.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module bt_wdt_ctrl
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [9:0] avs_address_in,
  input  wire logic       avs_read_in,
  input  wire logic       avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0] avs_byteenable_in,
  input  wire logic       osc_wake_in,
  output logic [31:0]     avs_readdata_out,
  output logic            avs_waitrequest_out,
  output logic            avs_response_err_out,
  output logic            sys_clk_en_out,
  output logic            bt_tick_out,
  output logic            wake_irq_out,
  output logic            sys_reset_out,
  output logic            irq_out
);

  typedef struct packed
  {
    bt_wdt_pkg::bus_state_e          bus;
    logic [7:0]                      btctl;
    logic [7:0]                      clkctl;
    logic [bt_wdt_pkg::DIV_W-1:0]    div;
    logic [bt_wdt_pkg::CNT_W-1:0]    cnt;
    logic [bt_wdt_pkg::EV_W-1:0]     stat;
    logic [bt_wdt_pkg::EV_W-1:0]     en;
    logic [3:0]                      rst_cnt;
    logic [31:0]                     rdata;
    logic                            err;
    logic                            sclk;
    logic                            tick;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // Division mask for the basic timer select code.
  function automatic logic [9:0] bt_mask(input logic [1:0] sel);
    unique case (sel)
      2'b01:   bt_mask = bt_wdt_pkg::DIV_1024_MASK;
      2'b10:   bt_mask = bt_wdt_pkg::DIV_128_MASK;
      2'b11:   bt_mask = bt_wdt_pkg::DIV_1024_MASK;
      default: bt_mask = bt_wdt_pkg::DIV_00_MASK;
    endcase
  endfunction

  // Division mask for the system clock select code.
  function automatic logic [9:0] cpu_mask(input logic [1:0] sel);
    unique case (sel)
      2'b00:   cpu_mask = bt_wdt_pkg::DIV_16_MASK;
      2'b01:   cpu_mask = bt_wdt_pkg::DIV_8_MASK;
      2'b10:   cpu_mask = bt_wdt_pkg::DIV_2_MASK;
      default: cpu_mask = bt_wdt_pkg::DIV_1_MASK;
    endcase
  endfunction

  logic       wr_go;
  logic       rd_go;
  logic       hit;
  logic       wdt_on;
  logic [1:0] bt_sel;
  logic [1:0] cpu_sel;
  logic [7:0] wbyte;
  logic [9:0] div_inc;
  logic       bt_edge;
  logic       ovf;
  logic [bt_wdt_pkg::EV_W-1:0] ev;

  // Decode of the request and of the control fields.
  always_comb
  begin
    wr_go   = avs_write_in && (state_r.bus == bt_wdt_pkg::BUS_IDLE);
    rd_go   = avs_read_in && (state_r.bus == bt_wdt_pkg::BUS_IDLE);
    hit     = (avs_address_in == bt_wdt_pkg::BTCTL_ADDR)
           || (avs_address_in == bt_wdt_pkg::CLKCTL_ADDR)
           || (avs_address_in == bt_wdt_pkg::IRQ_STAT_ADDR)
           || (avs_address_in == bt_wdt_pkg::IRQ_EN_ADDR)
           || (avs_address_in == bt_wdt_pkg::IRQ_CLR_ADDR)
           || (avs_address_in == bt_wdt_pkg::BTCNT_ADDR);
    wbyte   = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;
    // Only the exact code switches the watchdog off.
    wdt_on  = state_r.btctl[7:4] != bt_wdt_pkg::WDT_OFF_CODE;
    bt_sel  = state_r.btctl[bt_wdt_pkg::BT_SEL_LSB +: 2];
    cpu_sel = state_r.clkctl[bt_wdt_pkg::CPU_SEL_LSB +: 2];
    div_inc = state_r.div + 10'h001;
    bt_edge = (state_r.div & bt_mask(bt_sel)) == bt_mask(bt_sel);
    ovf     = bt_edge && (state_r.cnt == {bt_wdt_pkg::CNT_W{1'b1}});
    ev      = '0;
    ev[bt_wdt_pkg::EV_OVF]     = ovf;
    ev[bt_wdt_pkg::EV_INVALID] = (bt_sel == 2'b11);
  end

  // Next state: bus slave, registers, dividers, counter and reset pulse.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.bus = bt_wdt_pkg::BUS_IDLE;
    state_nxt.err = 1'b0;
    // Clear strobes only live for one cycle after the write.
    state_nxt.btctl[bt_wdt_pkg::BT_CNT_CLR] = 1'b0;
    state_nxt.btctl[bt_wdt_pkg::DIV_CLR] = 1'b0;
    state_nxt.div  = div_inc;
    state_nxt.sclk = (state_r.div & cpu_mask(cpu_sel)) == cpu_mask(cpu_sel);
    state_nxt.tick = bt_edge;
    if (bt_edge)
    begin
      state_nxt.cnt = state_r.cnt + 8'h01;
    end
    if (state_r.btctl[bt_wdt_pkg::DIV_CLR])
    begin
      state_nxt.div = '0;
    end
    if (state_r.btctl[bt_wdt_pkg::BT_CNT_CLR])
    begin
      state_nxt.cnt = '0;
    end
    if (ovf && wdt_on)
    begin
      state_nxt.rst_cnt = bt_wdt_pkg::SYSRST_LEN;
    end
    else if (state_r.rst_cnt != 4'h0)
    begin
      state_nxt.rst_cnt = state_r.rst_cnt - 4'h1;
    end
    state_nxt.stat = state_r.stat;
    if (wr_go || rd_go)
    begin
      state_nxt.bus = bt_wdt_pkg::BUS_ACK;
      state_nxt.err = !hit;
      state_nxt.rdata = 32'h0000_0000;
    end
    if (wr_go && avs_byteenable_in[0])
    begin
      unique case (avs_address_in)
        bt_wdt_pkg::BTCTL_ADDR:
          state_nxt.btctl = wbyte;
        bt_wdt_pkg::CLKCTL_ADDR:
          state_nxt.clkctl = wbyte & bt_wdt_pkg::CLKCTL_MASK;
        bt_wdt_pkg::IRQ_EN_ADDR:
          state_nxt.en = wbyte[bt_wdt_pkg::EV_W-1:0];
        bt_wdt_pkg::IRQ_CLR_ADDR:
          state_nxt.stat = state_r.stat & ~wbyte[bt_wdt_pkg::EV_W-1:0];
        default:
          state_nxt.stat = state_r.stat;
      endcase
    end
    if (rd_go)
    begin
      unique case (avs_address_in)
        bt_wdt_pkg::BTCTL_ADDR:    state_nxt.rdata[7:0] = state_r.btctl;
        bt_wdt_pkg::CLKCTL_ADDR:   state_nxt.rdata[7:0] = state_r.clkctl;
        bt_wdt_pkg::IRQ_STAT_ADDR: state_nxt.rdata[1:0] = state_r.stat;
        bt_wdt_pkg::IRQ_EN_ADDR:   state_nxt.rdata[1:0] = state_r.en;
        bt_wdt_pkg::BTCNT_ADDR:    state_nxt.rdata[7:0] = state_r.cnt;
        default:                   state_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Events set status bits and win over a clear in the same cycle.
    state_nxt.stat = state_nxt.stat | ev;
  end

  // State register with asynchronous active-low reset.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r         <= '0;
      state_r.btctl   <= bt_wdt_pkg::RESET_VAL;
      state_r.clkctl  <= bt_wdt_pkg::RESET_VAL;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs.
  always_comb
  begin
    avs_waitrequest_out  = (avs_read_in || avs_write_in) && (state_r.bus != bt_wdt_pkg::BUS_ACK);
    avs_readdata_out     = state_r.rdata;
    avs_response_err_out = state_r.err;
    sys_clk_en_out       = state_r.sclk;
    bt_tick_out          = state_r.tick;
    wake_irq_out         = osc_wake_in && !state_r.clkctl[bt_wdt_pkg::WAKE_MASK];
    sys_reset_out        = state_r.rst_cnt != 4'h0;
    irq_out              = |(state_r.stat & state_r.en);
  end

endmodule // bt_wdt_ctrl

/* core/bt_wdt_pkg.sv */
// Constants, field layouts and state types for the basic timer and clock control block.
package bt_wdt_pkg;
  // Register word byte addresses (printed offsets are not multiples of four).
  localparam logic [7:0]  BTCTL_INDEX   = 8'hD3;
  localparam logic [7:0]  CLKCTL_INDEX  = 8'hD4;
  localparam logic [9:0]  BTCTL_ADDR    = {BTCTL_INDEX, 2'b00};
  localparam logic [9:0]  CLKCTL_ADDR   = {CLKCTL_INDEX, 2'b00};
  localparam logic [9:0]  IRQ_STAT_ADDR = 10'h000;
  localparam logic [9:0]  IRQ_EN_ADDR   = 10'h004;
  localparam logic [9:0]  IRQ_CLR_ADDR  = 10'h008;
  localparam logic [9:0]  BTCNT_ADDR    = 10'h00C;
  // Field positions.
  localparam int          WDT_CODE_LSB  = 4;
  localparam int          BT_SEL_LSB    = 2;
  localparam int          BT_CNT_CLR    = 1;
  localparam int          DIV_CLR       = 0;
  localparam int          WAKE_MASK     = 7;
  localparam int          CPU_SEL_LSB   = 3;
  localparam logic [3:0]  WDT_OFF_CODE  = 4'hA;
  localparam logic [7:0]  CLKCTL_MASK   = 8'h98;
  localparam logic [7:0]  RESET_VAL     = 8'h00;
  // Prescaler and counter sizing.
  localparam int          DIV_W         = 10;
  localparam int          CNT_W         = 8;
  localparam logic [9:0]  DIV_1024_MASK = 10'h3FF;
  localparam logic [9:0]  DIV_128_MASK  = 10'h07F;
  localparam logic [9:0]  DIV_00_MASK   = 10'h1FF;
  localparam logic [9:0]  DIV_16_MASK   = 10'h00F;
  localparam logic [9:0]  DIV_8_MASK    = 10'h007;
  localparam logic [9:0]  DIV_2_MASK    = 10'h001;
  localparam logic [9:0]  DIV_1_MASK    = 10'h000;
  // Interrupt status bits.
  localparam int          EV_OVF        = 0;
  localparam int          EV_INVALID    = 1;
  localparam int          EV_W          = 2;
  // Length of the system reset pulse in clocks.
  localparam logic [3:0]  SYSRST_LEN    = 4'h8;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_e;
endpackage

/* dv/bt_wdt_ctrl_assertions.sv */
// Port checks for the basic timer, watchdog and clock control block.
`timescale 1ns/1ps
module bt_wdt_ctrl_assertions
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic        avs_waitrequest_out,
  input  wire logic [31:0] avs_readdata_out,
  input  wire logic        osc_wake_in,
  input  wire logic        wake_irq_out,
  input  wire logic        bt_tick_out,
  input  wire logic        sys_reset_out
);
  logic [10:0] gap_r;
  // Counts clocks since the last timer tick, saturating at the top.
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in)
      gap_r <= 11'h000;
    else
      gap_r <= bt_tick_out ? 11'h000 : gap_r + {10'h000, gap_r != 11'h7FF};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // The reset pulse is a fixed run of high cycles, then low.
  sequence rst_hold_s; sys_reset_out [*8]; endsequence
  sequence rst_end_s; !sys_reset_out; endsequence
  AST_RST_LEN: assert property ($rose(sys_reset_out) |-> rst_hold_s ##1 rst_end_s)
    else $error("system reset pulse length wrong");
  AST_RST_QUIET: assert property ($fell(sys_reset_out) |-> !sys_reset_out [*8])
    else $error("system reset repeated too soon");
  AST_RST_CAUSE: assert property ($rose(sys_reset_out) |->
    bt_tick_out || $past(bt_tick_out) || $past(bt_tick_out, 2))
    else $error("system reset without a timer tick");
  AST_TICK_GAP: assert property (bt_tick_out |-> gap_r >= 11'd127)
    else $error("timer tick faster than divide by 128");
  AST_WAKE_OFF: assert property (!osc_wake_in |-> !wake_irq_out)
    else $error("wake interrupt without oscillator wake");
  AST_BUS_ANS: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("bus answer late");
  AST_BUS_TAKE: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("bus answered at the request edge");
  AST_RD_UPPER: assert property (avs_read_in && !avs_waitrequest_out |->
    avs_readdata_out[31:8] == 24'h000000) else $error("upper read bits not zero");
endmodule // bt_wdt_ctrl_assertions
bind bt_wdt_ctrl bt_wdt_ctrl_assertions i_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .osc_wake_in(osc_wake_in),
  .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out),
  .wake_irq_out(wake_irq_out), .bt_tick_out(bt_tick_out), .sys_reset_out(sys_reset_out));

/* dv/bt_wdt_ctrl_tb.sv */
// Self-checking bench for the basic timer, watchdog and clock control block.
`timescale 1ns/1ps
module bt_wdt_ctrl_tb;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [9:0]  avs_address_in = 10'h000;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic        osc_wake_in = 1'b0;
  logic [31:0] avs_readdata_out, rd_q;
  logic        avs_waitrequest_out, avs_response_err_out, sys_clk_en_out, err_q;
  logic        bt_tick_out, wake_irq_out, sys_reset_out, irq_out, hit, rst;
  int          n_errors = 0;
  int          tests_run = 0;
  int          p;
  bt_wdt_ctrl i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(4'hF),
    .avs_writedata_in(avs_writedata_in), .osc_wake_in(osc_wake_in), .irq_out(irq_out),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_err_out(avs_response_err_out), .sys_clk_en_out(sys_clk_en_out),
    .bt_tick_out(bt_tick_out), .wake_irq_out(wake_irq_out), .sys_reset_out(sys_reset_out));
  // Free-running 125 MHz clock.
  always #4 clk_in = ~clk_in;
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {24'h000000, d};
    do
    begin
      @(posedge clk_in);
    end
    while (avs_waitrequest_out !== 1'b0);
    rd_q = avs_readdata_out;
    err_q = avs_response_err_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Reads one register and compares it.
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rd_q);
  endtask
  // Measures the clocks between pulses of the tick or the system clock enable.
  task automatic gap(input bit t);
    for (int k = 0; k < 3; k++)
    begin
      p = 0;
      do
      begin
        @(posedge clk_in);
        p++;
      end
      while ((t ? bt_tick_out : sys_clk_en_out) !== 1'b1);
    end
  endtask
  // Waits for the system reset or the interrupt, noting any system reset.
  task automatic hunt(input bit r);
    hit = 1'b0;
    rst = 1'b0;
    for (int c = 0; c < 34000 && !hit; c++)
    begin
      @(posedge clk_in);
      rst = rst | (sys_reset_out === 1'b1);
      hit = r ? sys_reset_out === 1'b1 : irq_out === 1'b1;
    end
  endtask
  // Reset values, slow start-up clock and an unmapped access.
  task automatic t_reset;
    gap(1'b0);
    chk("sclk_start", 16, p);
    gap(1'b1);
    chk("tick_sel00", 512, p);
    rd(bt_wdt_pkg::BTCTL_ADDR, 0, "btctl_rst");
    rd(bt_wdt_pkg::CLKCTL_ADDR, 0, "clkctl_rst");
    rd(10'h3FC, 0, "unmapped");
    chk("unmapped_err", 1, err_q);
    $display("test reset done");
  endtask
  // Every clock select code, unused bits and the wake mask.
  task automatic t_clk;
    int dv[4] = '{16, 8, 2, 1};
    for (int s = 0; s < 4; s++)
    begin
      bus(1'b1, bt_wdt_pkg::CLKCTL_ADDR, {3'b011, 2'(s), 3'b111});
      rd(bt_wdt_pkg::CLKCTL_ADDR, {27'h0, 2'(s), 3'h0}, "clkctl");
      gap(1'b0);
      chk("sclk_div", dv[s], p);
    end
    bus(1'b1, bt_wdt_pkg::CLKCTL_ADDR, 8'h80);
    osc_wake_in <= 1'b1;
    @(posedge clk_in);
    chk("wake_masked", 0, wake_irq_out);
    bus(1'b1, bt_wdt_pkg::CLKCTL_ADDR, 8'h00);
    chk("wake_open", 1, wake_irq_out);
    osc_wake_in <= 1'b0;
    $display("test clock done");
  endtask
  // Clear strobes, tick rates and the invalid select.
  task automatic t_clear;
    bus(1'b1, bt_wdt_pkg::BTCTL_ADDR, 8'h0B);
    rd(bt_wdt_pkg::BTCTL_ADDR, 32'h08, "autoclear");
    rd(bt_wdt_pkg::BTCNT_ADDR, 0, "count_clr");
    gap(1'b1);
    chk("tick_128", 128, p);
    bus(1'b1, bt_wdt_pkg::BTCTL_ADDR, 8'h07);
    gap(1'b1);
    chk("tick_1024", 1024, p);
    bus(1'b1, bt_wdt_pkg::BTCTL_ADDR, 8'h0D);
    rd(bt_wdt_pkg::IRQ_STAT_ADDR, 32'h2, "invalid_sel");
    $display("test clear done");
  endtask
  // Disabled watchdog: overflow only raises the interrupt.
  task automatic t_wdt_off;
    bus(1'b1, bt_wdt_pkg::BTCTL_ADDR, 8'hAB);
    bus(1'b1, bt_wdt_pkg::IRQ_CLR_ADDR, 8'h03);
    bus(1'b1, bt_wdt_pkg::IRQ_EN_ADDR, 8'h01);
    hunt(1'b0);
    chk("ovf_irq", 1, hit);
    chk("no_sysrst", 0, rst);
    bus(1'b1, bt_wdt_pkg::IRQ_EN_ADDR, 8'h00);
    chk("irq_masked", 0, irq_out);
    rd(bt_wdt_pkg::IRQ_STAT_ADDR, 32'h1, "ovf_stat");
    bus(1'b1, bt_wdt_pkg::IRQ_CLR_ADDR, 8'h01);
    rd(bt_wdt_pkg::IRQ_STAT_ADDR, 32'h0, "stat_clr");
    $display("test watchdog off done");
  endtask
  // Any other code keeps the watchdog on: overflow resets the system.
  task automatic t_wdt_on;
    bus(1'b1, bt_wdt_pkg::BTCTL_ADDR, 8'h5B);
    hunt(1'b1);
    chk("sysrst", 1, hit);
    repeat (12) @(posedge clk_in);
    $display("test watchdog on done");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after reset.
  initial
  begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_clk();
    t_clear();
    t_wdt_off();
    t_wdt_on();
    end_sim();
  end
  // Cuts a hang short well after the expected run length.
  initial
  begin
    #(100000 * 8);
    n_errors++;
    end_sim();
  end
endmodule // bt_wdt_ctrl_tb
